/* File: interrupt_vector_prioritizer.sv */
// Interrupt and exception vector prioritizer facing the processor core
// Functional notes
// - Pin reset or a watchdog internal reset gives code 0000H, handler 0, no restore address.
// - A valid edge on the non-maskable pin gives code 0010H, handler 10H, restore next PC.
// - First watchdog overflow in non-maskable mode gives code 0020H and handler 20H.
// - Second watchdog overflow in non-maskable mode gives code 0030H but handler 20H.
// - Illegal opcode or debug trap gives code 0060H, handler 60H, restore next PC.
// - First watchdog overflow in interval mode is maskable, default priority 0, code 0080H.
// - Edges on the seven external pins are maskable, priorities 1 to 7, codes 0090H to 00F0H.
// - Pulses on the eleven peripheral inputs are maskable, priorities 8 to 18, codes 0100H to 01A0H.
// - Software traps give 32 vectors in two groups of sixteen, each group its own handler.
module interrupt_vector_prioritizer
  import ivp_pkg::*;
#(
  parameter int MSK_CNT = MSK_N,
  parameter int LVL_W   = PRIO_W
) (
  // Clock and reset
  input  wire logic              CLK_SYS_I,
  input  wire logic              RESET_I,
  // Watchdogs
  input  wire logic              WDOG1_RESET_I,
  input  wire logic              WDOG2_RESET_I,
  input  wire logic              WDOG1_OVF_I,
  input  wire logic              WDOG1_NMI_MODE_I,
  input  wire logic              WDOG2_OVF_I,
  input  wire logic              WDOG2_NMI_MODE_I,
  // Pins, bit 0 non-maskable, bits 1..7 external requests
  input  wire logic [PIN_N-1:0]  PIN_I,
  input  wire logic [PIN_N-1:0]  PIN_EDGE_RISE_I,
  // Core exceptions
  input  wire trap_req_t         TRAP_I,
  input  wire logic              ILLEGAL_OP_I,
  input  wire logic              DEBUG_TRAP_I,
  // Peripheral pulses and maskable control
  input  wire logic [PERIPH_N-1:0] PERIPH_REQ_I,
  input  wire logic [MSK_N-1:0]  MSK_EN_I,
  input  wire prio_vec_t         PRIO_I,
  // Core handshake
  input  wire logic              ACK_I,
  output logic                   REQ_VALID_O,
  output logic [15:0]            EXC_CODE_O,
  output logic [31:0]            HANDLER_O,
  output logic                   RESTORE_NEXT_O,
  output logic                   REQ_MASKABLE_O,
  output logic [PRIO_W-1:0]      REQ_LEVEL_O
);

  if (MSK_CNT != MSK_N || LVL_W != PRIO_W) begin : g_chk
    $error("interrupt_vector_prioritizer: sizes must match the package");
  end

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [PIN_N-1:0] s1;
    logic [PIN_N-1:0] s2;
    logic [PIN_N-1:0] s3;
    logic [PIN_N-1:0] lvl;
    logic [SRC_N-1:0] pend;
    logic [4:0]       trap_num;
    logic [SRC_W-1:0] cur;
    vector_t          vec;
  } state_t;

  localparam logic [SRC_N-1:0] PEND_AT_RESET = 25'h000_0001;
  localparam logic [SRC_N-1:0] ONE_SRC       = 25'h000_0001;

  state_t s_r;
  state_t s_nxt;

  logic [PIN_N-1:0]  lvl_nxt;
  logic [PIN_N-1:0]  edge_v;
  logic [SRC_N-1:0]  set_v;
  logic [SRC_N-1:0]  clr_v;
  logic [SRC_N-1:0]  pend_nxt;
  logic              arb_valid;
  logic [MIDX_W-1:0] arb_idx;
  logic [PRIO_W-1:0] arb_level;
  logic [15:0]       msk_code;

  // ---------------------------------------------------------------------------
  // Pin filter and edge detect
  // ---------------------------------------------------------------------------
  for (genvar i = 0; i < PIN_N; i++) begin : g_pin
    assign lvl_nxt[i] = (s_r.s2[i] == s_r.s3[i]) ? s_r.s2[i] : s_r.lvl[i];
    assign edge_v[i]  = (lvl_nxt[i] != s_r.lvl[i]) && (lvl_nxt[i] == PIN_EDGE_RISE_I[i]);
  end

  // ---------------------------------------------------------------------------
  // Request capture
  // ---------------------------------------------------------------------------
  always_comb begin
    set_v = '0;
    set_v[SRC_RESET] = WDOG1_RESET_I | WDOG2_RESET_I;
    set_v[SRC_NMI]   = edge_v[0];
    set_v[SRC_WD1]   = WDOG1_OVF_I & WDOG1_NMI_MODE_I;
    set_v[SRC_WD2]   = WDOG2_OVF_I & WDOG2_NMI_MODE_I;
    set_v[SRC_ILLOP] = ILLEGAL_OP_I | DEBUG_TRAP_I;
    set_v[SRC_TRAP]  = TRAP_I.req;
    set_v[SRC_MSK + MSK_WDOG1] = WDOG1_OVF_I & ~WDOG1_NMI_MODE_I;
    set_v[SRC_MSK + MSK_PIN0 +: PIN_N-1] = edge_v[PIN_N-1:1];
    set_v[SRC_MSK + MSK_PERIPH +: PERIPH_N] = PERIPH_REQ_I;
  end

  // Acknowledge clears the presented source; a new event wins
  assign clr_v    = (ACK_I && s_r.vec.valid) ? (ONE_SRC << s_r.cur) : '0;
  assign pend_nxt = (s_r.pend & ~clr_v) | set_v;

  ivp_prio_arb #(
    .N (MSK_N),
    .W (PRIO_W)
  ) u_arb (
    .req_i   (pend_nxt[SRC_N-1:FIX_N] & MSK_EN_I),
    .prio_i  (PRIO_I),
    .valid_o (arb_valid),
    .idx_o   (arb_idx),
    .level_o (arb_level)
  );

  assign msk_code = CODE_MSK_BASE + (16'(arb_idx) << CODE_STEP_SH);

  // ---------------------------------------------------------------------------
  // Next state and vector selection
  // ---------------------------------------------------------------------------
  always_comb begin
    s_nxt      = s_r;
    s_nxt.s1   = PIN_I;
    s_nxt.s2   = s_r.s1;
    s_nxt.s3   = s_r.s2;
    s_nxt.lvl  = lvl_nxt;
    s_nxt.pend = pend_nxt;
    if (TRAP_I.req) begin
      s_nxt.trap_num = TRAP_I.num;
    end
    s_nxt.vec = '0;
    s_nxt.cur = SRC_RESET;
    if (pend_nxt[SRC_RESET]) begin
      s_nxt.vec.valid   = 1'b1;
      s_nxt.vec.code    = CODE_RESET;
      s_nxt.vec.handler = HND_RESET;
    end else if (pend_nxt[SRC_NMI]) begin
      s_nxt.cur = SRC_NMI;
      s_nxt.vec.valid        = 1'b1;
      s_nxt.vec.code         = CODE_NMI;
      s_nxt.vec.handler      = HND_NMI;
      s_nxt.vec.restore_next = 1'b1;
    end else if (pend_nxt[SRC_WD1]) begin
      s_nxt.cur = SRC_WD1;
      s_nxt.vec.valid   = 1'b1;
      s_nxt.vec.code    = CODE_WD1;
      s_nxt.vec.handler = HND_WDOG;
    end else if (pend_nxt[SRC_WD2]) begin
      s_nxt.cur = SRC_WD2;
      s_nxt.vec.valid   = 1'b1;
      s_nxt.vec.code    = CODE_WD2;
      s_nxt.vec.handler = HND_WDOG;
    end else if (pend_nxt[SRC_ILLOP]) begin
      s_nxt.cur = SRC_ILLOP;
      s_nxt.vec.valid        = 1'b1;
      s_nxt.vec.code         = CODE_ILLOP;
      s_nxt.vec.handler      = HND_ILLOP;
      s_nxt.vec.restore_next = 1'b1;
    end else if (pend_nxt[SRC_TRAP]) begin
      s_nxt.cur = SRC_TRAP;
      s_nxt.vec.valid        = 1'b1;
      s_nxt.vec.code         = CODE_TRAP_BASE | 16'(s_nxt.trap_num);
      s_nxt.vec.handler      = s_nxt.trap_num[4] ? HND_TRAP_B : HND_TRAP_A;
      s_nxt.vec.restore_next = 1'b1;
    end else if (arb_valid) begin
      s_nxt.cur = SRC_MSK + arb_idx;
      s_nxt.vec.valid        = 1'b1;
      s_nxt.vec.code         = msk_code;
      s_nxt.vec.handler      = {HND_HI_ZERO, msk_code};
      s_nxt.vec.restore_next = 1'b1;
      s_nxt.vec.maskable     = 1'b1;
      s_nxt.vec.level        = arb_level;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      s_r      <= '0;
      s_r.pend <= PEND_AT_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign REQ_VALID_O    = s_r.vec.valid;
  assign EXC_CODE_O     = s_r.vec.code;
  assign HANDLER_O      = s_r.vec.handler;
  assign RESTORE_NEXT_O = s_r.vec.restore_next;
  assign REQ_MASKABLE_O = s_r.vec.maskable;
  assign REQ_LEVEL_O    = s_r.vec.level;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RESET_I);

  AST_RESET_VECTOR: assert property ($fell(RESET_I) |=> REQ_VALID_O
      && EXC_CODE_O == CODE_RESET && HANDLER_O == HND_RESET && !RESTORE_NEXT_O)
    else $error("reset vector not presented after reset release");

  AST_NMI_PIN: assert property (s_r.pend[FIX_N-1:0] == '0 && set_v[SRC_RESET] == 1'b0
      && edge_v[0] |=> EXC_CODE_O == CODE_NMI && HANDLER_O == HND_NMI && RESTORE_NEXT_O)
    else $error("pin edge did not give the non-maskable vector");

  AST_WDOG1_NMI: assert property (REQ_VALID_O && EXC_CODE_O == CODE_WD1
      |-> HANDLER_O == HND_WDOG && !REQ_MASKABLE_O)
    else $error("first watchdog vector wrong");

  AST_WDOG2_NMI: assert property (s_r.pend[FIX_N-1:0] == '0 && set_v[SRC_WD1:0] == '0
      && WDOG2_OVF_I && WDOG2_NMI_MODE_I |=> EXC_CODE_O == CODE_WD2 && HANDLER_O == HND_WDOG)
    else $error("second watchdog vector wrong");

  AST_ILLOP: assert property (s_r.pend[FIX_N-1:0] == '0 && set_v[SRC_WD2:0] == '0
      && (ILLEGAL_OP_I || DEBUG_TRAP_I)
      |=> EXC_CODE_O == CODE_ILLOP && HANDLER_O == HND_ILLOP && RESTORE_NEXT_O)
    else $error("exception trap vector wrong");

  AST_WDOG1_MSK: assert property (s_r.pend == '0 && set_v == (ONE_SRC << SRC_MSK)
      && MSK_EN_I[MSK_WDOG1] |=> REQ_MASKABLE_O && EXC_CODE_O == CODE_MSK_BASE)
    else $error("interval watchdog vector wrong");

  AST_PIN_TIE: assert property (s_r.pend == '0 && set_v == (25'h000_0003 << 7)
      && MSK_EN_I[2:1] == 2'h3 && PRIO_I[1] == PRIO_I[2] |=> EXC_CODE_O == 16'h0090)
    else $error("equal level tie not granted to smaller default priority");

  AST_TRAP_GROUP: assert property (REQ_VALID_O && EXC_CODE_O[15:5] == CODE_TRAP_BASE[15:5]
      |-> HANDLER_O == (EXC_CODE_O[4] ? HND_TRAP_B : HND_TRAP_A))
    else $error("trap group handler wrong");

  AST_MSK_HANDLER: assert property (REQ_VALID_O && REQ_MASKABLE_O
      |-> HANDLER_O == {HND_HI_ZERO, EXC_CODE_O} && EXC_CODE_O >= CODE_MSK_BASE
      && EXC_CODE_O[3:0] == 4'h0)
    else $error("maskable handler not the code");

  AST_ACK_CLEARS: assert property (ACK_I && REQ_VALID_O && set_v == '0
      |=> s_r.pend == ($past(s_r.pend) & ~(ONE_SRC << $past(s_r.cur))))
    else $error("acknowledge did not retire the presented source");

endmodule

/* File: ivp_pkg.sv */
// Shared constants and carrier types for the interrupt vector prioritizer
package ivp_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int MSK_N    = 19;
  localparam int PRIO_W   = 3;
  localparam int PIN_N    = 8;
  localparam int PERIPH_N = 11;
  localparam int FIX_N    = 6;
  localparam int SRC_N    = FIX_N + MSK_N;
  localparam int SRC_W    = 5;
  localparam int MIDX_W   = 5;

  // ---------------------------------------------------------------------------
  // Source slots in the pending vector
  // ---------------------------------------------------------------------------
  localparam logic [SRC_W-1:0] SRC_RESET = 5'h00;
  localparam logic [SRC_W-1:0] SRC_NMI   = 5'h01;
  localparam logic [SRC_W-1:0] SRC_WD1   = 5'h02;
  localparam logic [SRC_W-1:0] SRC_WD2   = 5'h03;
  localparam logic [SRC_W-1:0] SRC_ILLOP = 5'h04;
  localparam logic [SRC_W-1:0] SRC_TRAP  = 5'h05;
  localparam logic [SRC_W-1:0] SRC_MSK   = 5'h06;

  // Maskable slot offsets
  localparam int MSK_WDOG1  = 0;
  localparam int MSK_PIN0   = 1;
  localparam int MSK_PERIPH = 8;

  // ---------------------------------------------------------------------------
  // Exception codes and handler addresses
  // ---------------------------------------------------------------------------
  localparam logic [15:0] CODE_RESET     = 16'h0000;
  localparam logic [15:0] CODE_NMI       = 16'h0010;
  localparam logic [15:0] CODE_WD1       = 16'h0020;
  localparam logic [15:0] CODE_WD2       = 16'h0030;
  localparam logic [15:0] CODE_TRAP_BASE = 16'h0040;
  localparam logic [15:0] CODE_ILLOP     = 16'h0060;
  localparam logic [15:0] CODE_MSK_BASE  = 16'h0080;
  localparam int          CODE_STEP_SH   = 4;

  localparam logic [31:0] HND_RESET  = 32'h0000_0000;
  localparam logic [31:0] HND_NMI    = 32'h0000_0010;
  localparam logic [31:0] HND_WDOG   = 32'h0000_0020;
  localparam logic [31:0] HND_TRAP_A = 32'h0000_0040;
  localparam logic [31:0] HND_TRAP_B = 32'h0000_0050;
  localparam logic [31:0] HND_ILLOP  = 32'h0000_0060;
  localparam logic [15:0] HND_HI_ZERO = 16'h0000;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef logic [MSK_N-1:0][PRIO_W-1:0] prio_vec_t;

  typedef struct packed {
    logic       req;
    logic [4:0] num;
  } trap_req_t;

  typedef struct packed {
    logic              valid;
    logic [15:0]       code;
    logic [31:0]       handler;
    logic              restore_next;
    logic              maskable;
    logic [PRIO_W-1:0] level;
  } vector_t;

endpackage

/* File: ivp_prio_arb.sv */
// Lowest-level-first arbiter for the maskable requests
module ivp_prio_arb
  import ivp_pkg::*;
#(
  parameter int N = MSK_N,
  parameter int W = PRIO_W
) (
  // Requests
  input  wire logic [N-1:0]        req_i,
  input  wire logic [N-1:0][W-1:0] prio_i,
  // Grant
  output logic                     valid_o,
  output logic [MIDX_W-1:0]        idx_o,
  output logic [W-1:0]             level_o
);

  if (N < 1 || N > (1 << MIDX_W)) begin : g_chk
    $error("ivp_prio_arb: N out of range");
  end

  // Strict less-than keeps the lowest index on a tie
  always_comb begin
    valid_o = 1'b0;
    idx_o   = '0;
    level_o = '0;
    for (int i = 0; i < N; i++) begin
      if (req_i[i] && (!valid_o || prio_i[i] < level_o)) begin
        valid_o = 1'b1;
        idx_o   = MIDX_W'(i);
        level_o = prio_i[i];
      end
    end
  end

endmodule

/* File: ivp_core_model.sv */
// Behavioural processor core that takes presented vectors
module ivp_core_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Vector handshake
  input  wire logic       valid_i,
  input  wire logic       take_en_i,
  input  wire logic [3:0] dly_i,
  output logic            ack_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] wait_r;

  // Ack once the vector has stood dly_i cycles; one-cycle pulse
  always @(posedge clk_i) begin
    if (reset_i || !valid_i || ack_o) begin
      wait_r <= 4'h0;
      ack_o  <= 1'b0;
    end else if (wait_r < dly_i) begin
      wait_r <= wait_r + 4'h1;
    end else begin
      ack_o <= take_en_i;
    end
  end
endmodule

/* File: testbench.sv */
// Self-checking bench for the interrupt vector prioritizer
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ivp_pkg::*;

  logic                clk_sys = 1'b0;
  logic                reset   = 1'b1;
  logic                wd1_rst = 1'b0, wd2_rst = 1'b0, wd1_ovf = 1'b0, wd2_ovf = 1'b0;
  logic                wd1_nmi = 1'b1, wd2_nmi = 1'b1, ill_op = 1'b0, dbg = 1'b0;
  logic [PIN_N-1:0]    pins    = 8'h00;
  logic [PIN_N-1:0]    rise    = 8'hFF;
  trap_req_t           trap    = '0;
  logic [PERIPH_N-1:0] periph  = '0;
  logic [MSK_N-1:0]    msk_en  = '1;
  prio_vec_t           prio    = '0;
  logic                ack, take_en = 1'b0, valid, restore, maskable;
  logic [3:0]          dly     = 4'h0;
  logic [15:0]         code;
  logic [31:0]         hnd;
  logic [PRIO_W-1:0]   level;
  int                  fail_count = 0, cmp_count = 0, cyc = 0;

  always #2.5 clk_sys = ~clk_sys;

  interrupt_vector_prioritizer uut (
    .CLK_SYS_I(clk_sys), .RESET_I(reset), .WDOG1_RESET_I(wd1_rst), .WDOG2_RESET_I(wd2_rst),
    .WDOG1_OVF_I(wd1_ovf), .WDOG1_NMI_MODE_I(wd1_nmi), .WDOG2_OVF_I(wd2_ovf),
    .WDOG2_NMI_MODE_I(wd2_nmi), .PIN_I(pins), .PIN_EDGE_RISE_I(rise), .TRAP_I(trap),
    .ILLEGAL_OP_I(ill_op), .DEBUG_TRAP_I(dbg), .PERIPH_REQ_I(periph), .MSK_EN_I(msk_en),
    .PRIO_I(prio), .ACK_I(ack), .REQ_VALID_O(valid), .EXC_CODE_O(code), .HANDLER_O(hnd),
    .RESTORE_NEXT_O(restore), .REQ_MASKABLE_O(maskable), .REQ_LEVEL_O(level));

  ivp_core_model core (.clk_i(clk_sys), .reset_i(reset), .valid_i(valid),
    .take_en_i(take_en), .dly_i(dly), .ack_o(ack));

  // ---------------------------------------------------------------------------
  // Common tasks
  // ---------------------------------------------------------------------------
  task automatic close_out;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Wait for a vector, compare it, then let the core take it
  task automatic expect_vec(input logic [15:0] c, input logic [31:0] h, input logic r,
                            input logic m, input logic [2:0] l);
    int n;
    n = 0;
    while (valid !== 1'b1 && n < 30) begin
      tick(1);
      n++;
    end
    chk("valid", valid, 32'h1);
    chk("code", code, c);
    chk("handler", hnd, h);
    chk("restore", restore, r);
    chk("maskable", maskable, m);
    if (m) chk("level", level, l);
    take_en = 1'b1;
    n = 0;
    while (ack !== 1'b1 && n < 30) begin
      tick(1);
      n++;
    end
    take_en = 1'b0;
    tick(1);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    expect_vec(16'h0000, 32'h0000_0000, 1'b0, 1'b0, 3'h0);
    wd1_rst = 1'b1;
    tick(1);
    wd1_rst = 1'b0;
    expect_vec(16'h0000, 32'h0000_0000, 1'b0, 1'b0, 3'h0);
    wd2_rst = 1'b1;
    tick(1);
    wd2_rst = 1'b0;
    expect_vec(16'h0000, 32'h0000_0000, 1'b0, 1'b0, 3'h0);
  endtask

  task automatic t_nmi_pin;
    pins[0] = 1'b1;
    expect_vec(16'h0010, 32'h0000_0010, 1'b1, 1'b0, 3'h0);
    rise[0] = 1'b0;
    tick(2);
    pins[0] = 1'b0;
    expect_vec(16'h0010, 32'h0000_0010, 1'b1, 1'b0, 3'h0);
  endtask

  task automatic t_wdog_nmi;
    wd1_ovf = 1'b1;
    tick(1);
    wd1_ovf = 1'b0;
    expect_vec(16'h0020, 32'h0000_0020, 1'b0, 1'b0, 3'h0);
    wd2_ovf = 1'b1;
    tick(1);
    wd2_ovf = 1'b0;
    expect_vec(16'h0030, 32'h0000_0020, 1'b0, 1'b0, 3'h0);
  endtask

  task automatic t_exc_trap;
    ill_op = 1'b1;
    tick(1);
    ill_op = 1'b0;
    expect_vec(16'h0060, 32'h0000_0060, 1'b1, 1'b0, 3'h0);
    dbg = 1'b1;
    tick(1);
    dbg = 1'b0;
    expect_vec(16'h0060, 32'h0000_0060, 1'b1, 1'b0, 3'h0);
    for (int i = 0; i < 32; i++) begin
      trap.num = 5'(i);
      trap.req = 1'b1;
      tick(1);
      trap.req = 1'b0;
      expect_vec(16'h0040 + 16'(i), i[4] ? 32'h0000_0050 : 32'h0000_0040,
                 1'b1, 1'b0, 3'h0);
    end
  endtask

  // Each maskable slot alone, with its own programmed level
  task automatic t_mask_table;
    wd1_nmi = 1'b0;
    for (int s = 0; s < MSK_N; s++) prio[s] = 3'(s);
    for (int s = 0; s < MSK_N; s++) begin
      if (s == 0) wd1_ovf = 1'b1;
      else if (s < 8) pins[s] = 1'b1;
      else periph[s-8] = 1'b1;
      tick(1);
      wd1_ovf = 1'b0;
      periph  = '0;
      expect_vec(16'h0080 + 16'(s * 16), 32'h0000_0080 + 32'(s * 16), 1'b1, 1'b1,
                 3'(s));
      pins = 8'h00;
      tick(2);
    end
  endtask

  // Simultaneous burst: exception first, then level, then default order
  task automatic t_order;
    int ord[11] = '{18, 0, 8, 10, 11, 12, 13, 14, 15, 16, 17};
    prio = '0;
    for (int s = 0; s < MSK_N; s++) prio[s] = 3'h2;
    prio[18] = 3'h1;
    msk_en[9] = 1'b0;
    dly = 4'h3;
    wd1_ovf = 1'b1;
    ill_op = 1'b1;
    periph = '1;
    tick(1);
    wd1_ovf = 1'b0;
    ill_op = 1'b0;
    periph = '0;
    expect_vec(16'h0060, 32'h0000_0060, 1'b1, 1'b0, 3'h0);
    foreach (ord[k]) expect_vec(16'h0080 + 16'(ord[k] * 16), 32'h0000_0080 + 32'(ord[k] * 16),
                                1'b1, 1'b1, ord[k] == 18 ? 3'h1 : 3'h2);
    tick(4);
    chk("masked idle", valid, 32'h0);
    msk_en[9] = 1'b1;
    expect_vec(16'h0110, 32'h0000_0110, 1'b1, 1'b1, 3'h2);
    // Two pins at one level in the same cycle
    pins[2:1] = 2'b11;
    expect_vec(16'h0090, 32'h0000_0090, 1'b1, 1'b1, 3'h2);
    expect_vec(16'h00A0, 32'h0000_00A0, 1'b1, 1'b1, 3'h2);
    pins = 8'h00;
  endtask

  initial begin
    tick(5);
    reset = 1'b0;
    t_reset();
    t_nmi_pin();
    t_wdog_nmi();
    t_exc_trap();
    t_mask_table();
    t_order();
    close_out();
  end
endmodule
